// *** osd_fmt_map.svh ***
// Offsets, field positions, reset values and timing counts of the display formatter
`ifndef OSD_FMT_MAP_SVH
`define OSD_FMT_MAP_SVH
`define OSD_RAM_WORDS    80
`define OSD_LINE_BYTES   16
`define OSD_LINES        5
`define OSD_COLS         15
`define OSD_FIFO_DEPTH   8
`define OSD_REG_VSTART   6'h10
`define OSD_REG_HSTART   6'h11
`define OSD_REG_VSPACE   6'h12
`define OSD_REG_HSPACE   6'h13
`define OSD_REG_BACK     6'h14
`define OSD_REG_MASTER   6'h17
`define OSD_RAM_PAGE6_TOP 6'h0f
`define OSD_RAM_PAGE6_BASE 7'h40
`define OSD_REG_RESET    8'h00
`define OSD_SPACE_BIT    6
`define OSD_SIZE_BIT     6
`define OSD_RED_BIT      5
`define OSD_BLUE_BIT     3
`define OSD_PICK_BIT     2
`define OSD_SHOW_BIT     1
`define OSD_GAP_BIT      0
`define OSD_CODE_HI      5
`define OSD_NUM_HI       5
`define OSD_FLAG_BIT     6
`define OSD_GS_LOW_BIT   6
`define OSD_GS_HIGH_BIT  7
`define OSD_BACK_A_LO    0
`define OSD_BACK_B_LO    3
`define OSD_BACK_A_ON    6
`define OSD_BACK_B_ON    7
`define OSD_HSTART_BASE  7'd10
`define OSD_GLYPH_COLS   3'd6
`define OSD_LAST_ROW     4'd8
`define OSD_CLK_NS       20
`define OSD_TDOT_NS      40
`define OSD_TDOT_CLKS    ((`OSD_TDOT_NS + `OSD_CLK_NS - 1) / `OSD_CLK_NS)
`endif

// *** osd_fmt_pkg.sv ***
// Types shared by the display formatter
package osd_fmt_pkg;
	typedef enum logic [1:0] {
		V_IDLE = 2'b00,
		V_ROWS = 2'b01,
		V_GAP  = 2'b11,
		V_DONE = 2'b10
	} osd_vstate_t;
	typedef enum logic [2:0] {
		R_WAIT  = 3'b000,
		R_FETCH = 3'b001,
		R_LOAD  = 3'b011,
		R_DOTS  = 3'b010,
		R_END   = 3'b110
	} osd_rstate_t;
endpackage

// *** osd_fmt.sv ***
// Character format decoder and pixel generator with its line FIFO
// Summary of operation
// - Master enable off suppresses colour; BLANK still follows spacing register bit 6
// - Master on: each word shown by bit
// - Line opens with format byte, never drawn
// - Bit 6 marks space; else glyph code
// - Five attribute bits steer following word
// - 6x9 dots, 2H by one dot period
// - No gaps when both gap bits clear
// - Glyph cells abut; spacing comes from font
// - Size from line bit and global bits
// - Line gap from spacing register or zero
// - Word gap: space width plus register
// - Space byte field layout decode
// - Colour bits drive red green blue
// - Backdrop pick chooses enable and colour
// - Hidden word unless show and master
// - Format byte field layout decode
// - Two glyph banks, one per screen
// - Five lines of fifteen columns
// - Origin in dot steps and 4H steps
// - Word spacing 64 steps of dots
// - Line spacing 63 steps of 4H
// - Sync inputs, RGB and blank outputs
// - Size code table to height, width
// - Only master enable and bank select writable while on
`include "osd_fmt_map.svh"

module osd_fifo #(
	parameter int W = 8,
	parameter int D = `OSD_FIFO_DEPTH
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	assign in_ready  = (count != D[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready & ~clr;
	assign pop       = out_valid & out_ready & ~clr;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end
endmodule

module osd_fmt (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        HSYNC,
	input  wire logic        VSYNC,
	input  wire logic        CPU_WE,
	input  wire logic        CPU_RE,
	input  wire logic        CPU_PAGE6,
	input  wire logic [5:0]  CPU_ADDR,
	input  wire logic [7:0]  CPU_WDATA,
	input  wire logic        BANK_WE,
	input  wire logic [5:0]  GLYPH_DOTS,
	output logic      [7:0]  CPU_RDATA,
	output logic      [10:0] GLYPH_ADDR,
	output logic             R,
	output logic             G,
	output logic             B,
	output logic             BLANK
);
	import osd_fmt_pkg::*;

	logic [7:0]  ram [`OSD_RAM_WORDS];
	logic [7:0]  vstart;
	logic [7:0]  hstart;
	logic [7:0]  vspace;
	logic [7:0]  hspace;
	logic [7:0]  back;
	logic        display_master_on;
	logic        bank;
	logic        hsync_d;
	logic        vsync_d;
	logic        h_edge;
	logic        v_edge;
	logic [8:0]  line_cnt;
	osd_vstate_t vstate;
	logic [2:0]  vline;
	logic [2:0]  line_m;
	logic [2:0]  row_sub;
	logic [3:0]  grow;
	logic [7:0]  gap_left;
	logic        scan_go;
	logic        fetching;
	logic [3:0]  fetch_idx;
	logic        fifo_ready;
	logic        fifo_valid;
	logic [7:0]  fifo_data;
	logic        fifo_pop;
	osd_rstate_t rstate;
	logic        dot_en;
	logic [6:0]  start_cnt;
	logic [4:0]  col;
	logic [2:0]  fg;
	logic        backdrop_pick;
	logic        word_show;
	logic        is_space;
	logic [5:0]  dots;
	logic [2:0]  dot_sub;
	logic [2:0]  dot_idx;
	logic [6:0]  extra;
	logic        fg_on;
	logic        bg_on;
	logic [2:0]  bg_rgb;
	logic [6:0]  wr_ram_addr;
	logic [7:0]  fmt_now;
	logic [7:0]  fmt_next;

	function automatic logic [2:0] size_mult(input logic [2:0] code);
		case (code)
			3'h0, 3'h2:       size_mult = 3'h1;
			3'h1, 3'h4, 3'h6: size_mult = 3'h2;
			3'h3, 3'h5:       size_mult = 3'h3;
			default:          size_mult = 3'h4;
		endcase
	endfunction

	function automatic logic [2:0] line_size(input logic [7:0] hs, input logic [7:0] f);
		line_size = size_mult({hs[`OSD_GS_HIGH_BIT], hs[`OSD_GS_LOW_BIT], f[`OSD_SIZE_BIT]});
	endfunction

	function automatic logic [6:0] line_base(input logic [2:0] l);
		line_base = {l, 4'h0};
	endfunction

	assign wr_ram_addr = CPU_PAGE6 ? (`OSD_RAM_PAGE6_BASE + {1'b0, CPU_ADDR}) : {1'b0, CPU_ADDR};
	assign fmt_now     = ram[line_base(vline)];
	assign fmt_next    = ram[line_base(vline + 3'h1)];
	assign h_edge      = HSYNC & ~hsync_d;
	assign v_edge      = VSYNC & ~vsync_d;
	assign fifo_pop    = (rstate == R_FETCH);

	always_ff @(posedge CLK) begin
		if (CPU_WE && !display_master_on &&
		    (!CPU_PAGE6 || CPU_ADDR <= `OSD_RAM_PAGE6_TOP)) begin
			ram[wr_ram_addr] <= CPU_WDATA;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			vstart            <= `OSD_REG_RESET;
			hstart            <= `OSD_REG_RESET;
			vspace            <= `OSD_REG_RESET;
			hspace            <= `OSD_REG_RESET;
			back              <= `OSD_REG_RESET;
			display_master_on <= 1'b0;
			bank              <= 1'b0;
		end else begin
			if (CPU_WE && CPU_PAGE6 && CPU_ADDR == `OSD_REG_MASTER) begin
				display_master_on <= CPU_WDATA[0];
			end
			if (CPU_WE && CPU_PAGE6 && !display_master_on) begin
				case (CPU_ADDR)
					`OSD_REG_VSTART: vstart <= CPU_WDATA;
					`OSD_REG_HSTART: hstart <= CPU_WDATA;
					`OSD_REG_VSPACE: vspace <= CPU_WDATA;
					`OSD_REG_HSPACE: hspace <= CPU_WDATA;
					`OSD_REG_BACK:   back   <= CPU_WDATA;
					default:         ;
				endcase
			end
			if (BANK_WE) begin
				bank <= CPU_WDATA[0];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CPU_RDATA <= 8'h00;
		end else if (CPU_RE && !display_master_on &&
		             (!CPU_PAGE6 || CPU_ADDR <= `OSD_RAM_PAGE6_TOP)) begin
			CPU_RDATA <= ram[wr_ram_addr];
		end else begin
			CPU_RDATA <= 8'h00;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			hsync_d  <= 1'b0;
			vsync_d  <= 1'b0;
			line_cnt <= 9'h000;
		end else begin
			hsync_d <= HSYNC;
			vsync_d <= VSYNC;
			if (v_edge) begin
				line_cnt <= 9'h000;
			end else if (h_edge && line_cnt != 9'h1ff) begin
				line_cnt <= line_cnt + 9'h001;
			end
		end
	end

	// Vertical sequencing through lines, dot rows and gaps
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			vstate   <= V_IDLE;
			vline    <= 3'h0;
			line_m   <= 3'h1;
			row_sub  <= 3'h0;
			grow     <= 4'h0;
			gap_left <= 8'h00;
			scan_go  <= 1'b0;
		end else begin
			scan_go <= 1'b0;
			if (v_edge) begin
				vstate <= V_IDLE;
			end else if (h_edge) begin
				case (vstate)
					V_IDLE: begin
						if (line_cnt == {vstart[`OSD_NUM_HI:0], 2'b00, 1'b0} >> 1) begin
							vstate  <= V_ROWS;
							vline   <= 3'h0;
							line_m  <= line_size(hspace, ram[line_base(3'h0)]);
							row_sub <= 3'h0;
							grow    <= 4'h0;
							scan_go <= 1'b1;
						end
					end
					V_ROWS: begin
						// Dot row spans 2H times size
						if (row_sub != {line_m[1:0], 1'b0} - 3'h1) begin
							row_sub <= row_sub + 3'h1;
							scan_go <= 1'b1;
						end else if (grow != `OSD_LAST_ROW) begin
							row_sub <= 3'h0;
							grow    <= grow + 4'h1;
							scan_go <= 1'b1;
						end else if (fmt_now[`OSD_GAP_BIT] && vspace[`OSD_NUM_HI:0] != 6'h00) begin
							vstate   <= V_GAP;
							gap_left <= {vspace[`OSD_NUM_HI:0], 2'b00} - 8'h01;
						end else begin
							if (vline == 3'(`OSD_LINES - 1)) begin
								vstate <= V_DONE;
							end else begin
								vline   <= vline + 3'h1;
								line_m  <= line_size(hspace, fmt_next);
								row_sub <= 3'h0;
								grow    <= 4'h0;
								scan_go <= 1'b1;
							end
						end
					end
					V_GAP: begin
						if (gap_left != 8'h00) begin
							gap_left <= gap_left - 8'h01;
						end else if (vline == 3'(`OSD_LINES - 1)) begin
							vstate <= V_DONE;
						end else begin
							vstate  <= V_ROWS;
							vline   <= vline + 3'h1;
							line_m  <= line_size(hspace, fmt_next);
							row_sub <= 3'h0;
							grow    <= 4'h0;
							scan_go <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Feed line bytes in address order
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			fetching  <= 1'b0;
			fetch_idx <= 4'h0;
		end else if (scan_go) begin
			fetching  <= 1'b1;
			fetch_idx <= 4'h0;
		end else if (fetching && fifo_ready) begin
			fetch_idx <= fetch_idx + 4'h1;
			if (fetch_idx == 4'(`OSD_COLS)) begin
				fetching <= 1'b0;
			end
		end
	end

	osd_fifo #(
		.W (8),
		.D (`OSD_FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.clr       (scan_go),
		.in_valid  (fetching),
		.in_ready  (fifo_ready),
		.in_data   (ram[line_base(vline) + {3'h0, fetch_idx}]),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			dot_en <= 1'b0;
		end else if (scan_go) begin
			dot_en <= 1'b0;
		end else begin
			dot_en <= (`OSD_TDOT_CLKS > 1) ? ~dot_en : 1'b1;
		end
	end

	// Horizontal cell sequencing
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rstate        <= R_END;
			start_cnt     <= 7'h00;
			col           <= 5'h00;
			fg            <= 3'h0;
			backdrop_pick <= 1'b0;
			word_show     <= 1'b0;
			is_space      <= 1'b0;
			dots          <= 6'h00;
			dot_sub       <= 3'h0;
			dot_idx       <= 3'h0;
			extra         <= 7'h00;
			GLYPH_ADDR    <= 11'h000;
		end else if (scan_go) begin
			rstate    <= R_WAIT;
			start_cnt <= 7'h00;
			col       <= 5'h00;
		end else begin
			case (rstate)
				R_WAIT: begin
					if (dot_en) begin
						if (start_cnt == `OSD_HSTART_BASE + {1'b0, hstart[`OSD_NUM_HI:0]}) begin
							rstate <= R_FETCH;
						end else begin
							start_cnt <= start_cnt + 7'h01;
						end
					end
				end
				R_FETCH: begin
					if (col == 5'(`OSD_LINE_BYTES)) begin
						rstate <= R_END;
					end else if (fifo_valid) begin
						col     <= col + 5'h01;
						dot_sub <= 3'h0;
						dot_idx <= 3'h0;
						if (col == 5'h00 || fifo_data[`OSD_SPACE_BIT]) begin
							fg            <= fifo_data[`OSD_RED_BIT:`OSD_BLUE_BIT];
							backdrop_pick <= fifo_data[`OSD_PICK_BIT];
							word_show     <= fifo_data[`OSD_SHOW_BIT];
						end
						if (col != 5'h00 && fifo_data[`OSD_SPACE_BIT]) begin
							extra       <= fifo_data[`OSD_GAP_BIT] ?
							               {1'b0, hspace[`OSD_NUM_HI:0]} + 7'h01 : 7'h00;
							is_space    <= 1'b1;
							rstate      <= R_DOTS;
						end else if (col != 5'h00) begin
							GLYPH_ADDR <= {bank, fifo_data[`OSD_CODE_HI:0], grow};
							is_space   <= 1'b0;
							extra      <= 7'h00;
							rstate     <= R_LOAD;
						end
					end
				end
				R_LOAD: begin
					dots   <= GLYPH_DOTS;
					rstate <= R_DOTS;
				end
				R_DOTS: begin
					if (dot_en) begin
						// Glyph cells abut; a space with its gap bit set adds extra dots
						if (dot_idx != `OSD_GLYPH_COLS) begin
							if (dot_sub == line_m - 3'h1) begin
								dot_sub <= 3'h0;
								dot_idx <= dot_idx + 3'h1;
								if (dot_idx == `OSD_GLYPH_COLS - 3'h1 && extra == 7'h00) begin
									rstate <= R_FETCH;
								end
							end else begin
								dot_sub <= dot_sub + 3'h1;
							end
						end else if (extra == 7'h01) begin
							extra  <= 7'h00;
							rstate <= R_FETCH;
						end else begin
							extra <= extra - 7'h01;
						end
					end
				end
				default: ;
			endcase
		end
	end

	assign bg_rgb = backdrop_pick ? back[`OSD_BACK_B_LO+2:`OSD_BACK_B_LO] :
	                                back[`OSD_BACK_A_LO+2:`OSD_BACK_A_LO];
	assign bg_on  = (backdrop_pick ? back[`OSD_BACK_B_ON] : back[`OSD_BACK_A_ON]) &
	                ~(is_space & hstart[`OSD_FLAG_BIT]);
	assign fg_on  = ~is_space & (dot_idx < `OSD_GLYPH_COLS) & dots[3'h5 - dot_idx];

	// Pixel output stage
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			R     <= 1'b0;
			G     <= 1'b0;
			B     <= 1'b0;
			BLANK <= 1'b0;
		end else if (rstate == R_DOTS && display_master_on && word_show) begin
			// Show only when both enables set
			if (fg_on) begin
				{R, G, B} <= fg;
				BLANK     <= 1'b1;
			end else if (bg_on) begin
				{R, G, B} <= bg_rgb;
				BLANK     <= 1'b1;
			end else begin
				{R, G, B} <= 3'h0;
				BLANK     <= vspace[`OSD_FLAG_BIT];
			end
		end else begin
			{R, G, B} <= 3'h0;
			BLANK     <= vspace[`OSD_FLAG_BIT];
		end
	end
endmodule

// *** osd_fmt_checker.sv ***
// Port-level checks for the display formatter
`include "osd_fmt_map.svh"
module osd_fmt_checker (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        HSYNC,
	input wire logic        VSYNC,
	input wire logic        CPU_WE,
	input wire logic        CPU_RE,
	input wire logic        CPU_PAGE6,
	input wire logic [5:0]  CPU_ADDR,
	input wire logic [7:0]  CPU_WDATA,
	input wire logic        BANK_WE,
	input wire logic [5:0]  GLYPH_DOTS,
	input wire logic [7:0]  CPU_RDATA,
	input wire logic [10:0] GLYPH_ADDR,
	input wire logic        R,
	input wire logic        G,
	input wire logic        B,
	input wire logic        BLANK
);
	logic       master_q;
	logic       scb_q;
	logic [6:0] off_cnt;
	logic       reg_we;
	assign reg_we = CPU_WE && CPU_PAGE6;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			master_q <= 1'b0;
		end else if (reg_we && CPU_ADDR == `OSD_REG_MASTER) begin
			master_q <= CPU_WDATA[0];
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			scb_q <= 1'b0;
		end else if (reg_we && !master_q && CPU_ADDR == `OSD_REG_VSPACE) begin
			scb_q <= CPU_WDATA[6];
		end
	end
	// Cycles since master off and no write
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			off_cnt <= 7'd0;
		end else if (master_q || CPU_WE) begin
			off_cnt <= 7'd0;
		end else if (off_cnt != 7'h7f) begin
			off_cnt <= off_cnt + 7'd1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	rdata_idle_a: assert property (
		CPU_RDATA != 8'h00 |-> $past(CPU_RE)) else $error("read data without a read");
	rdata_locked_a: assert property (
		$past(CPU_RE) && $past(master_q) |-> CPU_RDATA == 8'h00) else $error("locked read data");
	rdata_drop_a: assert property (
		CPU_RDATA != 8'h00 && !CPU_RE |=> CPU_RDATA == 8'h00) else $error("read data held");
	colour_blank_a: assert property (
		(R || G || B) |-> BLANK) else $error("colour without blanking");
	dark_off_a: assert property (
		off_cnt >= 7'd64 |-> {R, G, B} == 3'b000) else $error("colour while display off");
	blank_off_a: assert property (
		off_cnt >= 7'd64 |-> BLANK == scb_q) else $error("blanking while display off");
	row_range_a: assert property (
		GLYPH_ADDR[3:0] <= 4'd8) else $error("glyph row beyond nine");
	reset_quiet_a: assert property (
		$fell(RST) |-> {R, G, B, BLANK} == 4'h0 && CPU_RDATA == 8'h00) else $error("outputs after reset");
endmodule

bind osd_fmt osd_fmt_checker u_chk (.CLK(CLK), .RST(RST), .HSYNC(HSYNC), .VSYNC(VSYNC),
	.CPU_WE(CPU_WE), .CPU_RE(CPU_RE), .CPU_PAGE6(CPU_PAGE6), .CPU_ADDR(CPU_ADDR),
	.CPU_WDATA(CPU_WDATA), .BANK_WE(BANK_WE), .GLYPH_DOTS(GLYPH_DOTS), .CPU_RDATA(CPU_RDATA),
	.GLYPH_ADDR(GLYPH_ADDR), .R(R), .G(G), .B(B), .BLANK(BLANK));

// *** osd_video_model.sv ***
// Sync source and glyph ROM standing in for the TV side
module osd_video_model (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [5:0]  dots_pat,
	input  wire logic [10:0] GLYPH_ADDR,
	output logic             HSYNC,
	output logic             VSYNC,
	output logic      [5:0]  GLYPH_DOTS
);
	timeunit 1ns;
	timeprecision 1ps;
	int pix;
	int line;
	always @(negedge CLK) begin
		if (RST) begin
			pix <= 0;
			line <= 0;
		end else begin
			pix <= (pix == 399) ? 0 : pix + 1;
			if (pix == 399) begin
				line <= (line == 24) ? 0 : line + 1;
			end
		end
	end
	assign HSYNC = !RST && pix < 10;
	assign VSYNC = !RST && line == 0 && pix >= 200;
	assign GLYPH_DOTS = (GLYPH_ADDR[3:0] <= 4'd8) ? dots_pat : ~dots_pat;
endmodule

// *** test_osd_fmt.sv ***
// Self-checking bench for the display formatter
`include "osd_fmt_map.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
	$display("BAD t=%0t got %0h exp %0h", $time, got, exp); end end
module test_osd_fmt;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK, RST, CPU_WE, CPU_RE, CPU_PAGE6, BANK_WE;
	logic        HSYNC, VSYNC, R, G, B, BLANK;
	logic [5:0]  CPU_ADDR;
	logic [7:0]  CPU_WDATA;
	logic [7:0]  CPU_RDATA;
	logic [5:0]  GLYPH_DOTS;
	logic [5:0]  dots_pat;
	logic [10:0] GLYPH_ADDR;
	logic [7:0]  seen;
	logic        bank_seen;
	logic        line_lit;
	int          lit_lines;
	logic [6:0]  i;
	logic [5:0]  k;
	int          num_errors = 0;
	int          tests_run = 0;
	osd_fmt DUT (.CLK(CLK), .RST(RST), .HSYNC(HSYNC), .VSYNC(VSYNC), .CPU_WE(CPU_WE),
		.CPU_RE(CPU_RE), .CPU_PAGE6(CPU_PAGE6), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
		.BANK_WE(BANK_WE), .GLYPH_DOTS(GLYPH_DOTS), .CPU_RDATA(CPU_RDATA),
		.GLYPH_ADDR(GLYPH_ADDR), .R(R), .G(G), .B(B), .BLANK(BLANK));
	osd_video_model u_tv (.CLK(CLK), .RST(RST), .dots_pat(dots_pat), .GLYPH_ADDR(GLYPH_ADDR),
		.HSYNC(HSYNC), .VSYNC(VSYNC), .GLYPH_DOTS(GLYPH_DOTS));
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (BLANK === 1'b1) begin
			seen[{R, G, B}] <= 1'b1;
			line_lit        <= 1'b1;
		end
		if (GLYPH_ADDR[10] === 1'b1) begin
			bank_seen <= 1'b1;
		end
	end
	// Count scanlines that carried any lit pixel
	always @(posedge HSYNC) begin
		if (line_lit === 1'b1) begin
			lit_lines <= lit_lines + 1;
		end
		line_lit <= 1'b0;
	end
	task automatic wr(input logic page, input logic [5:0] addr, input logic [7:0] data);
		CPU_PAGE6 = page;
		CPU_ADDR = addr;
		CPU_WDATA = data;
		CPU_WE = 1'b1;
		@(negedge CLK);
		CPU_WE = 1'b0;
		@(negedge CLK);
	endtask
	task automatic rd(input logic page, input logic [5:0] addr, input logic [7:0] exp);
		CPU_PAGE6 = page;
		CPU_ADDR = addr;
		CPU_RE = 1'b1;
		@(negedge CLK);
		CPU_RE = 1'b0;
		`CHK(CPU_RDATA, exp)
		@(negedge CLK);
	endtask
	task automatic frame();
		@(posedge VSYNC);
		seen = 8'h00;
		bank_seen = 1'b0;
		line_lit = 1'b0;
		lit_lines = 0;
		@(posedge VSYNC);
		@(negedge CLK);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge CLK);
		num_errors++;
		complete_run();
	end
	initial begin
		RST = 1'b1;
		{CPU_WE, CPU_RE, CPU_PAGE6, BANK_WE} = 4'h0;
		CPU_ADDR = 6'h00;
		CPU_WDATA = 8'h00;
		dots_pat = 6'h3f;
		seen = 8'h00;
		bank_seen = 1'b0;
		line_lit = 1'b0;
		lit_lines = 0;
		repeat (20) @(negedge CLK);
		RST = 1'b0;
		@(negedge CLK);
		for (i = 0; i < 80; i++) begin
			wr(i >= 7'd64, i[5:0], 8'h00);
		end
		wr(1'b0, 6'h00, 8'h0a);
		for (k = 1; k < 8; k++) begin
			wr(1'b0, k * 6'd2 - 6'd1, 8'h01);
			wr(1'b0, k * 6'd2, {2'b01, k[2:0] + 3'd1, 1'b0, k < 6, 1'b0});
		end
		wr(1'b0, 6'h0f, 8'h01);
		rd(1'b0, 6'h0f, 8'h01);
		rd(1'b1, `OSD_REG_VSTART, 8'h00);
		wr(1'b1, 6'h05, 8'h3c);
		rd(1'b1, 6'h05, 8'h3c);
		wr(1'b1, 6'h15, 8'hff);
		wr(1'b1, `OSD_REG_VSTART, 8'h01);
		wr(1'b1, `OSD_REG_MASTER, 8'h01);
		wr(1'b0, 6'h03, 8'h55);
		rd(1'b0, 6'h03, 8'h00);
		frame();
		`CHK(seen, 8'h7e)
		`CHK(bank_seen, 1'b0)
		`CHK(lit_lines, 18)
		wr(1'b1, `OSD_REG_MASTER, 8'h00);
		rd(1'b0, 6'h03, 8'h01);
		wr(1'b1, `OSD_REG_BACK, 8'hae);
		wr(1'b1, `OSD_REG_HSPACE, 8'h40);
		wr(1'b0, 6'h00, 8'h16);
		for (k = 2; k < 16; k += 2) begin
			wr(1'b0, k, 8'h01);
		end
		CPU_WDATA = 8'h01;
		BANK_WE = 1'b1;
		@(negedge CLK);
		BANK_WE = 1'b0;
		dots_pat = 6'h30;
		wr(1'b1, `OSD_REG_MASTER, 8'h01);
		frame();
		`CHK(seen, 8'h24)
		`CHK(bank_seen, 1'b1)
		`CHK(lit_lines, 18)
		wr(1'b1, `OSD_REG_MASTER, 8'h00);
		wr(1'b1, `OSD_REG_VSPACE, 8'h40);
		frame();
		`CHK(seen, 8'h01)
		complete_run();
	end
endmodule
